// File: design/ocdp_cfg.svh
// register indices, field positions, reset values for the output channel
// configuration block; assumes it is included by bare name
`ifndef OCDP_CFG_SVH
`define OCDP_CFG_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define OCDP_IDX_CH2_DRV     6'h25
`define OCDP_IDX_CH2_SE      6'h26
`define OCDP_IDX_CH3_DIV_LO  6'h27
`define OCDP_IDX_CH3_DIV_HI  6'h28
`define OCDP_IDX_CH3_PH_LO   6'h29
`define OCDP_IDX_CH3_PH_HI   6'h2a
`define OCDP_IDX_STATUS      6'h30

// =====================================================================
// channel-two driver control fields
`define OCDP_DRV_PD_BIT      7
`define OCDP_DRV_SYNCX_BIT   6
`define OCDP_DRV_POL_HI      5
`define OCDP_DRV_POL_LO      4
`define OCDP_DRV_FMT_HI      3
`define OCDP_DRV_FMT_LO      1
// channel-two single-ended control fields
`define OCDP_SE_PEN_BIT      7
`define OCDP_SE_PPOL_HI      6
`define OCDP_SE_PPOL_LO      5
`define OCDP_SE_NEN_BIT      4
`define OCDP_SE_NPOL_HI      3
`define OCDP_SE_NPOL_LO      2

// =====================================================================
// writable bit masks; reserved bits store nothing and read zero
`define OCDP_MASK_CH2_DRV    8'hfe
`define OCDP_MASK_CH2_SE     8'hfc
`define OCDP_MASK_DIV_HI     8'h03
`define OCDP_MASK_PH_HI      8'h07

// =====================================================================
// reset values
`define OCDP_RST_CH2_DRV     8'h14
`define OCDP_RST_CH2_SE      8'h00
`define OCDP_RST_CH3         8'h00

// =====================================================================
// bus answers and timing
`define OCDP_RESP_OKAY       2'b00
`define OCDP_RESP_SLVERR     2'b10
`define OCDP_CLK_PERIOD_NS   4

`endif

// File: design/ocdp_pkg.sv
// types shared by the output channel configuration block
// assumes nothing beyond a SystemVerilog compiler

package ocdp_pkg;

  // =====================================================================
  // polarity codes of a driver
  typedef enum logic [1:0] {
    OCDP_POL_HIGH   = 2'b00,
    OCDP_POL_PASS   = 2'b01,
    OCDP_POL_INVERT = 2'b10,
    OCDP_POL_LOW    = 2'b11
  } ocdp_pol_type;

  // =====================================================================
  // channel-two pin group
  typedef struct packed {
    logic       main_p;
    logic       main_n;
    logic       main_oe_n;
    logic [2:0] driver_format_select;
    logic       pos_se;
    logic       pos_se_oe_n;
    logic       neg_se;
    logic       neg_se_oe_n;
  } ocdp_ch2_pins_type;

  // =====================================================================
  // divider state
  typedef struct packed {
    logic        waiting;
    logic [10:0] phase_cnt;
    logic [9:0]  div_cnt;
    logic        out;
  } ocdp_div_state_type;

endpackage : ocdp_pkg

// File: design/ocdp_divider.sv
// one channel divider with half-period phase offset
// assumes ref_edge pulses once per half period of the input clock, in the
// aclk domain

`timescale 1ns/1ps

module ocdp_divider (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ref_edge,
  input  wire logic        restart,
  input  wire logic        run,
  input  wire logic [9:0]  divide_value,
  input  wire logic [10:0] phase_offset,
  output logic             clk_out,
  output logic             phase_wait
);
  import ocdp_pkg::*;

  ocdp_div_state_type state_q;
  ocdp_div_state_type state_d;

  // =====================================================================
  // next state: restart arms the phase wait, then toggle every n+1 edges
  always_comb begin
    state_d = state_q;
    if (!run || restart) begin
      state_d.waiting   = 1'b1;
      state_d.phase_cnt = phase_offset;
      state_d.div_cnt   = 10'h000;
      state_d.out       = 1'b0;
    end else if (ref_edge) begin
      if (state_q.waiting) begin
        if (state_q.phase_cnt == 11'h000) begin
          state_d.waiting = 1'b0;
          state_d.out     = 1'b1;
        end else begin
          // one count per half input period
          state_d.phase_cnt = state_q.phase_cnt - 11'h001;
        end
      end else if (state_q.div_cnt >= divide_value) begin
        // n+1 half periods per level gives a period of n+1 inputs
        state_d.div_cnt = 10'h000;
        state_d.out     = ~state_q.out;
      end else begin
        state_d.div_cnt = state_q.div_cnt + 10'h001;
      end
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '{waiting: 1'b1, phase_cnt: 11'h000,
                   div_cnt: 10'h000, out: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign clk_out    = state_q.out;
  assign phase_wait = state_q.waiting;

endmodule : ocdp_divider

// File: design/ocdp_top.sv
// output channel configuration: AXI4-Lite registers, channel-two drivers
// and channel-three divider with phase offset
// assumes a single aclk domain; sync_request_pin is asynchronous
//
// Contract
// - driver control bit 6 set keeps channel two's divider out of syncs.
// - main polarity bits 5:4: high, pass, invert, low; default pass.
// - format bits 3:1; default 010; codes 110 and 111 float outputs.
// - positive single-ended driver enabled only by bit 7, reset off.
// - positive single-ended polarity bits 6:5; default forced high.
// - negative single-ended driver enabled only by bit 4, reset off.
// - negative single-ended polarity bits 3:2; default forced high.
// - channel-three divide value is ten bits, top two from ch3_divide_high.
// - channel three divides input by divide value plus one.
// - channel-three phase offset is eleven bits, top three from ch3_phase_high.
// - channel three is delayed by phase offset half input periods.

`timescale 1ns/1ps

`include "ocdp_cfg.svh"

module ocdp_top #(
  parameter int unsigned ADDR_WIDTH = 8,
  parameter logic [9:0]  CH2_DIVIDE = 10'h000,
  parameter logic [10:0] CH2_PHASE  = 11'h000
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ref_edge,
  input  wire logic                  sync_request_pin,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output ocdp_pkg::ocdp_ch2_pins_type ch2_pins,
  output logic                       ch3_clk_out
);
  import ocdp_pkg::*;

  // =====================================================================
  // state of the block
  typedef struct packed {
    logic [7:0]        ch2_drv;
    logic [7:0]        ch2_se;
    logic [7:0]        div_lo;
    logic [7:0]        div_hi;
    logic [7:0]        ph_lo;
    logic [7:0]        ph_hi;
    logic              aw_have;
    logic [5:0]        aw_idx;
    logic              w_have;
    logic [7:0]        w_byte;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [2:0]        sync_sr;
    logic              sync_level;
    logic              sync_pulse;
    ocdp_ch2_pins_type pins;
    logic              ch3_out;
  } ocdp_state_type;

  ocdp_state_type state_q;
  ocdp_state_type state_d;

  logic        ch2_div_out;
  logic        ch2_wait;
  logic        ch3_div_out;
  logic        ch3_wait;
  logic [9:0]  ch3_divide;
  logic [10:0] ch3_phase;
  logic        ch2_restart;
  logic        ch2_run;

  // =====================================================================
  // helpers
  // a forced level ignores the divider, so a powered-down channel still
  // shows a fixed high or low at the pin
  function automatic logic apply_pol(input logic [1:0] pol,
                                     input logic       clk);
    case (ocdp_pol_type'(pol))
      OCDP_POL_HIGH:   apply_pol = 1'b1;
      OCDP_POL_PASS:   apply_pol = clk;
      OCDP_POL_INVERT: apply_pol = ~clk;
      OCDP_POL_LOW:    apply_pol = 1'b0;
      default:         apply_pol = 1'b0;
    endcase
  endfunction : apply_pol

  // the status index answers okay although writes to it change nothing
  function automatic logic idx_mapped(input logic [5:0] idx);
    case (idx)
      `OCDP_IDX_CH2_DRV, `OCDP_IDX_CH2_SE, `OCDP_IDX_CH3_DIV_LO,
      `OCDP_IDX_CH3_DIV_HI, `OCDP_IDX_CH3_PH_LO, `OCDP_IDX_CH3_PH_HI,
      `OCDP_IDX_STATUS: idx_mapped = 1'b1;
      default:          idx_mapped = 1'b0;
    endcase
  endfunction : idx_mapped

  // word index from a byte address; the two low bits are ignored
  function automatic logic [5:0] addr_idx(input logic [ADDR_WIDTH-1:0] a);
    addr_idx = a[7:2];
  endfunction : addr_idx

  // =====================================================================
  // assembled channel-three fields and channel-two divider control
  assign ch3_divide  = {state_q.div_hi[1:0], state_q.div_lo};
  assign ch3_phase   = {state_q.ph_hi[2:0], state_q.ph_lo};
  assign ch2_run     = ~state_q.ch2_drv[`OCDP_DRV_PD_BIT];
  assign ch2_restart = state_q.sync_pulse &
                       ~state_q.ch2_drv[`OCDP_DRV_SYNCX_BIT];

  // =====================================================================
  // channel dividers
  // channel two has no divide or phase registers here, so its divider
  // runs from the module parameters
  ocdp_divider u_ch2_div (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ref_edge     (ref_edge),
    .restart      (ch2_restart),
    .run          (ch2_run),
    .divide_value (CH2_DIVIDE),
    .phase_offset (CH2_PHASE),
    .clk_out      (ch2_div_out),
    .phase_wait   (ch2_wait)
  );

  // channel three has no power-down of its own in this block, so it
  // always runs and always follows a sync
  ocdp_divider u_ch3_div (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ref_edge     (ref_edge),
    .restart      (state_q.sync_pulse),
    .run          (1'b1),
    .divide_value (ch3_divide),
    .phase_offset (ch3_phase),
    .clk_out      (ch3_div_out),
    .phase_wait   (ch3_wait)
  );

  // =====================================================================
  // next state: sync filter, bus slave, register writes, output drivers
  always_comb begin
    logic [7:0] wmask;
    logic [7:0] rd;
    logic       float_main;
    wmask      = 8'h00;
    rd         = 8'h00;
    float_main = 1'b0;
    state_d    = state_q;

    // three-stage synchroniser; level moves when stages two and three agree
    state_d.sync_sr = {state_q.sync_sr[1:0], sync_request_pin};
    if (state_q.sync_sr[1] == state_q.sync_sr[2]) begin
      state_d.sync_level = state_q.sync_sr[2];
    end
    state_d.sync_pulse = state_d.sync_level & ~state_q.sync_level;

    // write address and data are accepted in either order
    // a write lands only once both halves are held; reserved bits are
    // masked on the way in, so reads return only what was stored
    if (s_axi_awvalid && s_axi_awready) begin
      state_d.aw_have = 1'b1;
      state_d.aw_idx  = addr_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_d.w_have  = 1'b1;
      state_d.w_byte  = s_axi_wdata[7:0];
      state_d.w_lane0 = s_axi_wstrb[0];
    end
    if (state_q.aw_have && state_q.w_have) begin
      state_d.aw_have = 1'b0;
      state_d.w_have  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = idx_mapped(state_q.aw_idx) ? `OCDP_RESP_OKAY
                                                   : `OCDP_RESP_SLVERR;
      case (state_q.aw_idx)
        `OCDP_IDX_CH2_DRV:    wmask = `OCDP_MASK_CH2_DRV;
        `OCDP_IDX_CH2_SE:     wmask = `OCDP_MASK_CH2_SE;
        `OCDP_IDX_CH3_DIV_LO: wmask = 8'hff;
        `OCDP_IDX_CH3_DIV_HI: wmask = `OCDP_MASK_DIV_HI;
        `OCDP_IDX_CH3_PH_LO:  wmask = 8'hff;
        `OCDP_IDX_CH3_PH_HI:  wmask = `OCDP_MASK_PH_HI;
        default:              wmask = 8'h00;
      endcase
      if (state_q.w_lane0) begin
        case (state_q.aw_idx)
          `OCDP_IDX_CH2_DRV:    state_d.ch2_drv = state_q.w_byte & wmask;
          `OCDP_IDX_CH2_SE:     state_d.ch2_se  = state_q.w_byte & wmask;
          `OCDP_IDX_CH3_DIV_LO: state_d.div_lo  = state_q.w_byte & wmask;
          `OCDP_IDX_CH3_DIV_HI: state_d.div_hi  = state_q.w_byte & wmask;
          `OCDP_IDX_CH3_PH_LO:  state_d.ph_lo   = state_q.w_byte & wmask;
          `OCDP_IDX_CH3_PH_HI:  state_d.ph_hi   = state_q.w_byte & wmask;
          default:              state_d.ph_hi   = state_q.ph_hi;
        endcase
      end
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end

    // read: data captured when the address is taken
    // frozen data means a slow rready never sees it change while waiting
    if (s_axi_arvalid && s_axi_arready) begin
      case (addr_idx(s_axi_araddr))
        `OCDP_IDX_CH2_DRV:    rd = state_q.ch2_drv;
        `OCDP_IDX_CH2_SE:     rd = state_q.ch2_se;
        `OCDP_IDX_CH3_DIV_LO: rd = state_q.div_lo;
        `OCDP_IDX_CH3_DIV_HI: rd = state_q.div_hi;
        `OCDP_IDX_CH3_PH_LO:  rd = state_q.ph_lo;
        `OCDP_IDX_CH3_PH_HI:  rd = state_q.ph_hi;
        `OCDP_IDX_STATUS:     rd = {3'h0, state_q.sync_level, ch3_wait,
                                    ch2_wait, ch3_div_out, ch2_div_out};
        default:              rd = 8'h00;
      endcase
      state_d.rvalid = 1'b1;
      state_d.rdata  = rd;
      state_d.rresp  = idx_mapped(addr_idx(s_axi_araddr)) ?
                       `OCDP_RESP_OKAY : `OCDP_RESP_SLVERR;
    end else if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end

    // channel-two main driver: polarity, format, float in single-ended use
    state_d.pins.main_p = apply_pol(
      state_q.ch2_drv[`OCDP_DRV_POL_HI:`OCDP_DRV_POL_LO], ch2_div_out);
    state_d.pins.main_n = ~state_d.pins.main_p;
    state_d.pins.driver_format_select =
      state_q.ch2_drv[`OCDP_DRV_FMT_HI:`OCDP_DRV_FMT_LO];
    float_main = state_q.ch2_drv[`OCDP_DRV_FMT_HI] &
                 state_q.ch2_drv[`OCDP_DRV_FMT_HI-1];
    state_d.pins.main_oe_n = float_main;

    // channel-two single-ended legs
    state_d.pins.pos_se = apply_pol(
      state_q.ch2_se[`OCDP_SE_PPOL_HI:`OCDP_SE_PPOL_LO], ch2_div_out);
    state_d.pins.pos_se_oe_n = ~state_q.ch2_se[`OCDP_SE_PEN_BIT];
    state_d.pins.neg_se = apply_pol(
      state_q.ch2_se[`OCDP_SE_NPOL_HI:`OCDP_SE_NPOL_LO], ch2_div_out);
    state_d.pins.neg_se_oe_n = ~state_q.ch2_se[`OCDP_SE_NEN_BIT];

    // channel three passes straight to its output flop
    state_d.ch3_out = ch3_div_out;
  end

  // =====================================================================
  // state register with reset values
  // pins start as the default register values would drive them, so no
  // glitch appears on the first edge after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q         <= '0;
      state_q.ch2_drv <= `OCDP_RST_CH2_DRV;
      state_q.ch2_se  <= `OCDP_RST_CH2_SE;
      state_q.div_lo  <= `OCDP_RST_CH3;
      state_q.div_hi  <= `OCDP_RST_CH3;
      state_q.ph_lo   <= `OCDP_RST_CH3;
      state_q.ph_hi   <= `OCDP_RST_CH3;
      state_q.pins    <= '{main_p: 1'b0, main_n: 1'b1, main_oe_n: 1'b0,
                           driver_format_select: 3'h2,
                           pos_se: 1'b1, pos_se_oe_n: 1'b1,
                           neg_se: 1'b1, neg_se_oe_n: 1'b1};
    end else begin
      state_q <= state_d;
    end
  end

  // =====================================================================
  // outputs
  // ready signals are plain decodes of state; every data output below
  // comes straight from a flop
  assign s_axi_awready = ~state_q.aw_have & ~state_q.bvalid;
  assign s_axi_wready  = ~state_q.w_have & ~state_q.bvalid;
  assign s_axi_bvalid  = state_q.bvalid;
  assign s_axi_bresp   = state_q.bresp;
  assign s_axi_arready = ~state_q.rvalid;
  assign s_axi_rvalid  = state_q.rvalid;
  assign s_axi_rdata   = {24'h000000, state_q.rdata};
  assign s_axi_rresp   = state_q.rresp;
  assign ch2_pins      = state_q.pins;
  assign ch3_clk_out   = state_q.ch3_out;

endmodule : ocdp_top

// File: bench/ocdp_chk.sv
// checker for the output channel block: bus answers, pin defaults and
// channel-three edges; assumes a bind onto ocdp_top, one aclk domain
`timescale 1ns/1ps

module ocdp_chk (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        ref_edge,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire logic [31:0]                 s_axi_rdata,
  input wire ocdp_pkg::ocdp_ch2_pins_type ch2_pins,
  input wire logic                        ch3_clk_out
);
  import ocdp_pkg::*;

  // =====================================================================
  // properties, all on aclk, quiet while reset is held
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_MAIN_COMPL: assert property (ch2_pins.main_n == ~ch2_pins.main_p)
    else $error("main driver legs not complementary");
  AST_FMT_FLOAT: assert property (ch2_pins.main_oe_n ==
    (ch2_pins.driver_format_select[2:1] == 2'b11))
    else $error("main driver float does not follow format");
  AST_RST_MAIN: assert property ($rose(aresetn) |->
    ch2_pins.driver_format_select == 3'b010 && !ch2_pins.main_p)
    else $error("main driver not at default after reset");
  AST_RST_SE: assert property ($rose(aresetn) |-> ch2_pins.pos_se &&
    ch2_pins.neg_se && ch2_pins.pos_se_oe_n && ch2_pins.neg_se_oe_n)
    else $error("single-ended legs not at default after reset");
  AST_CH3_RISE: assert property ($rose(ch3_clk_out) |-> $past(ref_edge, 2))
    else $error("channel three rose without a reference edge");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
endmodule : ocdp_chk

bind ocdp_top ocdp_chk i_ocdp_chk (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .ref_edge      (ref_edge),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rdata   (s_axi_rdata),
  .ch2_pins      (ch2_pins),
  .ch3_clk_out   (ch3_clk_out)
);

// File: bench/tb_top.sv
// self-checking bench for the output channel block over AXI4-Lite
// assumes ocdp_top and ocdp_pkg; the checker is bound separately
`timescale 1ns/1ps

module tb_top;
  import ocdp_pkg::*;

  logic              aclk;
  logic              aresetn = 1'b0;
  logic              ref_edge = 1'b0, ref_on = 1'b0, ref_man = 1'b0;
  logic              sync_pin = 1'b0, ch3_prev = 1'b0;
  logic [7:0]        awaddr = 8'h0, araddr = 8'h0;
  logic [31:0]       wdata = 32'h0, rdata;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic [3:0]        strb = 4'hf;
  logic              awready, wready, bvalid, arready, rvalid, ch3;
  logic [1:0]        bresp, rresp;
  ocdp_ch2_pins_type pins;
  int                errors = 0, cmp_count = 0, cycles = 0;
  int                refs = 0, gap = 0, nchg = 0;

  ocdp_top i_ocdp_top (
    .aclk(aclk), .aresetn(aresetn), .ref_edge(ref_edge),
    .sync_request_pin(sync_pin), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ch2_pins(pins), .ch3_clk_out(ch3));

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // reference pulses, channel-three gap monitor and watchdog
  always @(posedge aclk) begin
    ref_edge <= (ref_on & ~ref_edge) | ref_man;
    ch3_prev <= ch3;
    cycles   <= cycles + 1;
    if (ch3 !== ch3_prev) begin
      gap  <= refs;
      refs <= 32'(ref_edge);
      nchg <= nchg + 1;
    end else
      refs <= refs + 32'(ref_edge);
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // write one register; address and data released as each is taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic aw, w;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw = 1'b1;
    w  = 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      aw = aw && awready !== 1'b1;
      w  = w && wready !== 1'b1;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask : wr

  // read one register and compare data and response
  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] d,
                        input logic [1:0] er);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", {24'h0, d}, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask : rd_chk

  task automatic ref_pulse();
    @(posedge aclk);
    ref_man <= 1'b1;
    @(posedge aclk);
    ref_man <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : ref_pulse

  task automatic pulse_sync();
    @(posedge aclk);
    sync_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    sync_pin <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : pulse_sync

  task automatic test_reset();
    chk("fmt", 32'h2, 32'(pins.driver_format_select));
    chk("main_p", 32'h0, 32'(pins.main_p));
    chk("se_oe_n", 32'h3, 32'({pins.pos_se_oe_n, pins.neg_se_oe_n}));
    chk("se", 32'h3, 32'({pins.pos_se, pins.neg_se}));
    for (int i = 0; i < 6; i++)
      rd_chk(6'h25 + 6'(i), (i == 0) ? 8'h14 : 8'h00, 2'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_regs();
    logic [7:0] m [6] = '{8'hfe, 8'hfc, 8'hff, 8'h03, 8'hff, 8'h07};
    for (int i = 0; i < 6; i++) begin
      wr(6'h25 + 6'(i), 8'hff, 2'h0);
      rd_chk(6'h25 + 6'(i), m[i], 2'h0);
    end
    wr(6'h31, 8'hff, 2'h2);
    rd_chk(6'h31, 8'h00, 2'h2);
    strb <= 4'he;
    wr(6'h27, 8'h5a, 2'h0);
    strb <= 4'hf;
    rd_chk(6'h27, 8'hff, 2'h0);
    for (int i = 0; i < 6; i++)
      wr(6'h25 + 6'(i), (i == 0) ? 8'h14 : 8'h00, 2'h0);
    $display("test regs done");
  endtask : test_regs

  // divider powered down, so pass and invert give fixed levels
  task automatic test_drive();
    logic seen;
    ref_on <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(6'h25, {2'b10, i[1:0], i[2:0], 1'b0}, 2'h0);
      repeat (4) @(posedge aclk);
      chk("main_p", 32'(!i[0]), 32'(pins.main_p));
      chk("fmt", 32'(i[2:0]), 32'(pins.driver_format_select));
      chk("main_oe_n", 32'(i >= 6), 32'(pins.main_oe_n));
    end
    for (int i = 0; i < 4; i++) begin
      wr(6'h26, {1'b1, i[1:0], 1'b1, i[1:0], 2'b00}, 2'h0);
      repeat (4) @(posedge aclk);
      chk("se", 32'({2{~i[0]}}), 32'({pins.pos_se, pins.neg_se}));
      chk("se_oe_n", 32'h0, 32'({pins.pos_se_oe_n, pins.neg_se_oe_n}));
    end
    wr(6'h26, 8'h30, 2'h0);
    repeat (4) @(posedge aclk);
    chk("se_oe_n", 32'h2, 32'({pins.pos_se_oe_n, pins.neg_se_oe_n}));
    wr(6'h25, 8'h14, 2'h0);
    seen = 1'b0;
    repeat (20) begin
      @(posedge aclk);
      seen = seen | pins.main_p;
    end
    chk("main_p running", 32'h1, 32'(seen));
    $display("test drive done");
  endtask : test_drive

  // park channel two high, then sync with and without exclusion
  task automatic test_sync();
    for (int x = 1; x >= 0; x--) begin
      ref_on <= 1'b1;
      wr(6'h25, {1'b0, x[0], 6'h14}, 2'h0);
      ref_on <= 1'b0;
      repeat (4) @(posedge aclk);
      if (pins.main_p !== 1'b1) ref_pulse();
      pulse_sync();
      chk("main_p after sync", 32'(x), 32'(pins.main_p));
      rd_chk(6'h30, x ? 8'h09 : 8'h0c, 2'h0);
    end
    $display("test sync done");
  endtask : test_sync

  task automatic test_div();
    logic [9:0] v [3] = '{10'h000, 10'h002, 10'h102};
    int c;
    ref_on <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wr(6'h27, v[k][7:0], 2'h0);
      wr(6'h28, {6'h0, v[k][9:8]}, 2'h0);
      c = nchg;
      while (nchg < c + 3) @(posedge aclk);
      chk("ch3 refs per half", 32'(v[k]) + 1, 32'(gap));
    end
    $display("test div done");
  endtask : test_div

  task automatic test_phase();
    logic [10:0] p [2] = '{11'h001, 11'h105};
    int n;
    ref_on <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      wr(6'h29, p[k][7:0], 2'h0);
      wr(6'h2a, {5'h0, p[k][10:8]}, 2'h0);
      pulse_sync();
      n = 0;
      while (ch3 !== 1'b1 && n < 300) begin
        ref_pulse();
        n++;
      end
      chk("ch3 refs to rise", 32'(p[k]) + 1, 32'(n));
    end
    $display("test phase done");
  endtask : test_phase

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset();
    test_regs();
    test_drive();
    test_sync();
    test_div();
    test_phase();
    tally_and_finish();
  end
endmodule : tb_top
